/* File: hw/laser_altimeter.sv */
// Laser altimeter ranging, fire control and telemetry word
//
// The address map and the address-and-strobe port were decided locally.
`include "altim_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module laser_altimeter #(
   parameter int          ALT_W   = `ALT_BITS,
   parameter logic [31:0] FIRE_GAP = 32'(`FIRE_GAP_CYC)
)(
   // Clock and reset
   input  wire logic                CLOCK_I,
   input  wire logic                RESETN_I,
   // Register port
   input  wire altim_pkg::reg_addr_t ADDR_I,
   input  wire altim_pkg::reg_data_t WDATA_I,
   input  wire logic                WR_I,
   input  wire logic                RD_I,
   output altim_pkg::reg_data_t     RDATA_O,
   // Instrument status inputs
   input  wire logic                SUPPLY_OK_I,
   input  wire logic                MOTOR_RUN_I,
   input  wire logic                TRIG_DISCHARGE_I,
   input  wire logic                ENERGY_LOW_I,
   input  wire logic                SUN_NEAR_I,
   input  wire logic                RETURN_I,
   // Survey camera
   input  wire logic                SURVEY_CAMERA_REQ_I,
   // Laser and shutter
   output logic                     FIRE_O,
   output logic                     SHUTTER_CLOSE_O,
   // Telemetry link
   input  wire logic                TLM_LOAD_I,
   input  wire logic                TLM_SHIFT_I,
   output logic                     TLM_DATA_O
);
   import altim_pkg::*;

   logic                   rst_meta;
   logic                   rst_n;
   // Reset release through two flops
   always_ff @(posedge CLOCK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Registers
   logic [2:0]             ctrl;
   logic [ALT_W-1:0]       min_alt;
   logic [ALT_W-1:0]       max_alt;
   reg_data_t              rdata;
   logic [2:0]             next_ctrl;
   logic [ALT_W-1:0]       next_min_alt;
   logic [ALT_W-1:0]       next_max_alt;
   reg_data_t              next_rdata;
   logic                   fire_cmd;
   // Time base
   logic [2:0]             tb_acc;
   logic [2:0]             next_tb_acc;
   logic                   tb_tick;
   // Ranging
   range_state_t           state;
   range_state_t           next_state;
   logic [ALT_W-1:0]       count;
   logic [ALT_W-1:0]       next_count;
   logic [ALT_W-1:0]       alt;
   logic [ALT_W-1:0]       next_alt;
   logic [31:0]            gap;
   logic [31:0]            next_gap;
   logic                   fire;
   logic                   next_fire;
   // Events
   logic                   trig_tgl;
   logic                   next_trig_tgl;
   logic                   low_tgl;
   logic                   next_low_tgl;
   logic                   low_prev;
   logic                   ovf;
   logic                   next_ovf;
   logic                   cam_seen;
   logic                   next_cam_seen;
   logic [`EVT_BITS-1:0]   events;
   logic [`WORD_BITS-1:0]  word;
   logic                   shutter;

   // Register write and read decode
   always_comb
   begin
      next_ctrl    = ctrl;
      next_min_alt = min_alt;
      next_max_alt = max_alt;
      next_rdata   = '0;
      fire_cmd     = 1'b0;
      if (WR_I)
      begin
         if (ADDR_I == `REG_CTRL)
         begin
            next_ctrl = {WDATA_I[`CTRL_SHUT], WDATA_I[`CTRL_AUTO], 1'b0};
            fire_cmd  = WDATA_I[`CTRL_FIRE];
         end
         else if (ADDR_I == `REG_MIN_ALT)
         begin
            next_min_alt = WDATA_I[ALT_W-1:0];
         end
         else if (ADDR_I == `REG_MAX_ALT)
         begin
            next_max_alt = WDATA_I[ALT_W-1:0];
         end
      end
      if (RD_I)
      begin
         if (ADDR_I == `REG_CTRL)
         begin
            next_rdata = {29'h0, ctrl};
         end
         else if (ADDR_I == `REG_STATUS)
         begin
            next_rdata = {23'h0, shutter, (gap != 32'h0),
                          (state == RS_COUNT), events};
         end
         else if (ADDR_I == `REG_ALT)
         begin
            next_rdata = {14'h0, alt};
         end
         else if (ADDR_I == `REG_MIN_ALT)
         begin
            next_rdata = {14'h0, min_alt};
         end
         else if (ADDR_I == `REG_MAX_ALT)
         begin
            next_rdata = {14'h0, max_alt};
         end
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl    <= `CTRL_RST;
         min_alt <= `MIN_ALT_RST;
         max_alt <= `MAX_ALT_RST;
         rdata   <= '0;
      end
      else
      begin
         ctrl    <= next_ctrl;
         min_alt <= next_min_alt;
         max_alt <= next_max_alt;
         rdata   <= next_rdata;
      end
   end

   // Fractional time base: three ticks in five clocks
   always_comb
   begin
      tb_tick     = 1'b0;
      next_tb_acc = tb_acc + `TB_NUM;
      if (next_tb_acc >= `TB_DEN)
      begin
         next_tb_acc = next_tb_acc - `TB_DEN;
         tb_tick     = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tb_acc <= 3'h0;
      end
      else
      begin
         tb_acc <= next_tb_acc;
      end
   end

   // Shutter follows sun sensor or software override
   assign shutter = SUN_NEAR_I | ctrl[`CTRL_SHUT];

   // Fire control and range counter
   always_comb
   begin
      next_state = state;
      next_count = count;
      next_alt   = alt;
      next_ovf   = ovf;
      next_fire  = 1'b0;
      next_gap   = (gap != 32'h0) ? gap - 32'h1 : gap;
      case (state)
         RS_IDLE:
         begin
            if ((fire_cmd || (ctrl[`CTRL_AUTO] && SURVEY_CAMERA_REQ_I)) &&
                (gap == 32'h0) && !shutter)
            begin
               next_fire  = 1'b1;
               next_gap   = FIRE_GAP;
               next_count = '0;
               next_ovf   = 1'b0;
               next_state = RS_COUNT;
            end
         end
         RS_COUNT:
         begin
            if (RETURN_I && (count >= min_alt))
            begin
               next_alt   = count;
               next_state = RS_IDLE;
            end
            else if (count >= max_alt)
            begin
               next_ovf   = 1'b1;
               next_state = RS_IDLE;
            end
            else if (tb_tick)
            begin
               next_count = count + 1'b1;
            end
         end
         default:
         begin
            next_state = RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= RS_IDLE;
         count <= '0;
         alt   <= '0;
         ovf   <= 1'b0;
         fire  <= 1'b0;
         gap   <= 32'h0;
      end
      else
      begin
         state <= next_state;
         count <= next_count;
         alt   <= next_alt;
         ovf   <= next_ovf;
         fire  <= next_fire;
         gap   <= next_gap;
      end
   end

   // Event bits
   always_comb
   begin
      next_trig_tgl = trig_tgl ^ TRIG_DISCHARGE_I;
      next_low_tgl  = low_tgl ^ (ENERGY_LOW_I & ~low_prev);
      next_cam_seen = cam_seen;
      if (TLM_LOAD_I)
      begin
         next_cam_seen = 1'b0;
      end
      if (SURVEY_CAMERA_REQ_I)
      begin
         next_cam_seen = 1'b1;
      end
   end

   always_ff @(posedge CLOCK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_tgl <= 1'b0;
         low_tgl  <= 1'b0;
         low_prev <= 1'b0;
         cam_seen <= 1'b0;
      end
      else
      begin
         trig_tgl <= next_trig_tgl;
         low_tgl  <= next_low_tgl;
         low_prev <= ENERGY_LOW_I;
         cam_seen <= next_cam_seen;
      end
   end

   always_comb
   begin
      events                = '0;
      events[`EVT_SUPPLY]   = SUPPLY_OK_I;
      events[`EVT_MOTOR]    = MOTOR_RUN_I;
      events[`EVT_TRIGGER]  = trig_tgl;
      events[`EVT_LASER_LOW] = low_tgl;
      events[`EVT_OVERFLOW] = ovf;
      events[`EVT_CAMERA]   = cam_seen | SURVEY_CAMERA_REQ_I;
   end

   // Word snapshot: altitude held in the shifter for the whole word
   assign word = {alt, events};

   tlm_shift #(
      .WIDTH   (`WORD_BITS)
   ) u_shift (
      .clk_i   (CLOCK_I),
      .rst_n_i (rst_n),
      .load_i  (TLM_LOAD_I),
      .shift_i (TLM_SHIFT_I),
      .word_i  (word),
      .bit_o   (TLM_DATA_O)
   );

   assign RDATA_O         = rdata;
   assign FIRE_O          = fire;
   assign SHUTTER_CLOSE_O = shutter;
endmodule : laser_altimeter
`default_nettype wire

/* File: shared/altim_cfg.svh */
// Offsets, field positions, reset values and timing counts of the altimeter
`ifndef ALTIM_CFG_SVH
`define ALTIM_CFG_SVH

// Register offsets (byte addresses)
`define REG_CTRL       8'h00
`define REG_STATUS     8'h04
`define REG_ALT        8'h08
`define REG_MIN_ALT    8'h0c
`define REG_MAX_ALT    8'h10

// Control fields
`define CTRL_FIRE      0
`define CTRL_AUTO      1
`define CTRL_SHUT      2

// Status fields
`define STAT_RANGING   6
`define STAT_GAP_BUSY  7
`define STAT_SHUTTER   8

// Word layout
`define WORD_BITS      24
`define ALT_BITS       18
`define EVT_BITS       6
`define EVT_SUPPLY     5
`define EVT_MOTOR      4
`define EVT_TRIGGER    3
`define EVT_LASER_LOW  2
`define EVT_OVERFLOW   1
`define EVT_CAMERA     0

// Reset values
`define CTRL_RST       3'h0
`define MIN_ALT_RST    18'h00000
`define MAX_ALT_RST    18'h3ffff

// Timing: system clock and time-base ratio (3 ticks every 5 clocks = 150 MHz)
`define CLK_MHZ        250
`define TB_NUM         3'h3
`define TB_DEN         3'h5
// Least spacing of shots for 3.75 pulses per minute: 16 s
`define FIRE_GAP_US    16000000
`define FIRE_GAP_CYC   (64'd`FIRE_GAP_US * 64'd`CLK_MHZ)

`endif

/* File: shared/altim_pkg.sv */
// Types shared by the altimeter design
package altim_pkg;
   typedef logic [7:0]  reg_addr_t;
   typedef logic [31:0] reg_data_t;
   typedef enum logic [1:0]
   {
      RS_IDLE  = 2'b01,
      RS_COUNT = 2'b10
   } range_state_t;
endpackage : altim_pkg

/* File: hw/tlm_shift.sv */
// Parallel-load shift register that sends a word MSB first
`timescale 1ns/100ps
`default_nettype none
module tlm_shift #(
   parameter int WIDTH = 24
)(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Load and shift
   input  wire logic             load_i,
   input  wire logic             shift_i,
   input  wire logic [WIDTH-1:0] word_i,
   // Serial out
   output logic                  bit_o
);
   logic [WIDTH-1:0] sreg;
   logic [WIDTH-1:0] next_sreg;

   always_comb
   begin
      next_sreg = sreg;
      if (load_i)
      begin
         next_sreg = word_i;
      end
      else if (shift_i)
      begin
         next_sreg = {sreg[WIDTH-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sreg <= '0;
      end
      else
      begin
         sreg <= next_sreg;
      end
   end

   assign bit_o = sreg[WIDTH-1];
endmodule : tlm_shift
`default_nettype wire

/* File: dv/altim_asserts.sv */
// Port checker for the altimeter
`timescale 1ns/100ps
`default_nettype none
module altim_asserts #(
   parameter logic [31:0] FIRE_GAP = 32'd100
)(
   // Watched ports
   input wire logic                 CLOCK_I,
   input wire logic                 RESETN_I,
   input wire altim_pkg::reg_addr_t ADDR_I,
   input wire logic                 RD_I,
   input wire altim_pkg::reg_data_t RDATA_O,
   input wire logic                 SUPPLY_OK_I,
   input wire logic                 SUN_NEAR_I,
   input wire logic                 FIRE_O,
   input wire logic                 SHUTTER_CLOSE_O,
   input wire logic                 TLM_LOAD_I,
   input wire logic                 TLM_SHIFT_I,
   input wire logic                 TLM_DATA_O
);
   import altim_pkg::*;
   logic [31:0] since;
   logic [4:0]  pos;
   logic        sup;
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // Cycles since last shot, bit slot on the line
   always_ff @(posedge CLOCK_I or negedge RESETN_I)
      if (!RESETN_I)
      begin
         since <= FIRE_GAP;
         pos   <= 5'h18;
         sup   <= 1'b0;
      end
      else
      begin
         since <= FIRE_O ? 32'h0 : since + 32'h1;
         if (TLM_LOAD_I)
            pos <= 5'h0;
         else if (TLM_SHIFT_I && pos != 5'h1f)
            pos <= pos + 5'h1;
         if (TLM_LOAD_I)
            sup <= SUPPLY_OK_I;
      end
   sequence s_rd_alt;
      RD_I && ADDR_I == 8'h08;
   endsequence
   property p_shut;
      SUN_NEAR_I |-> SHUTTER_CLOSE_O;
   endproperty
   property p_fire_len;
      FIRE_O |=> !FIRE_O;
   endproperty
   property p_gap;
      FIRE_O |-> since >= FIRE_GAP - 32'd2;
   endproperty
   property p_fire_shut;
      FIRE_O |-> !$past(SHUTTER_CLOSE_O);
   endproperty
   property p_alt_w;
      s_rd_alt |=> RDATA_O[31:18] == 14'h0;
   endproperty
   property p_hold;
      !TLM_LOAD_I && !TLM_SHIFT_I |=> $stable(TLM_DATA_O);
   endproperty
   property p_sup;
      pos == 5'h12 |-> TLM_DATA_O == sup;
   endproperty
   property p_tail;
      pos >= 5'h18 |-> !TLM_DATA_O;
   endproperty
   a_shut: assert property (p_shut) else $error("shutter open with sun near");
   a_fire_len: assert property (p_fire_len) else $error("long fire pulse");
   a_gap: assert property (p_gap) else $error("shots too close");
   a_fire_shut: assert property (p_fire_shut) else $error("fired with shutter shut");
   a_alt_w: assert property (p_alt_w) else $error("altitude wider than field");
   a_hold: assert property (p_hold) else $error("serial bit moved");
   a_sup: assert property (p_sup) else $error("supply bit wrong");
   a_tail: assert property (p_tail) else $error("bits past word end");
endmodule : altim_asserts
bind laser_altimeter altim_asserts #(.FIRE_GAP(FIRE_GAP)) u_chk (
   .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .SUPPLY_OK_I(SUPPLY_OK_I), .SUN_NEAR_I(SUN_NEAR_I),
   .FIRE_O(FIRE_O), .SHUTTER_CLOSE_O(SHUTTER_CLOSE_O), .TLM_LOAD_I(TLM_LOAD_I),
   .TLM_SHIFT_I(TLM_SHIFT_I), .TLM_DATA_O(TLM_DATA_O)
);
`default_nettype wire

/* File: dv/tlm_sampler.sv */
// Telemetry sampler model: load, then shift and capture 24 bits
`timescale 1ns/100ps
`default_nettype none
module tlm_sampler (
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   input  wire logic   start_i,
   input  wire logic   slow_i,
   input  wire logic   data_i,
   output logic        load_o,
   output logic        shift_o,
   output logic [23:0] word_o,
   output logic        done_o
);
   logic [4:0] left;
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
      begin
         load_o  <= 1'b0;
         shift_o <= 1'b0;
         word_o  <= 24'h0;
         done_o  <= 1'b0;
         left    <= 5'h0;
      end
      else
      begin
         load_o  <= start_i && left == 5'h0;
         done_o  <= 1'b0;
         shift_o <= left != 5'h0 && !(shift_o && left == 5'h1) && (!slow_i || !shift_o);
         if (start_i && left == 5'h0)
            left <= 5'h18;
         if (shift_o)
         begin
            word_o <= {word_o[22:0], data_i};
            left   <= left - 5'h1;
            done_o <= left == 5'h1;
         end
      end
endmodule : tlm_sampler
`default_nettype wire

/* File: dv/tb.sv */
// Testbench for altimeter ranging and telemetry word
`timescale 1ns/100ps
`default_nettype none
module tb;
   import altim_pkg::*;
   logic        clk;
   logic        rst_n;
   reg_addr_t   addr;
   reg_data_t   wdata;
   reg_data_t   rdata;
   reg_data_t   alt;
   logic        wr;
   logic        rd;
   logic [4:0]  lvl;
   logic [2:0]  pls;
   logic        fire;
   logic        shut;
   logic        tdat;
   logic        load;
   logic        shift;
   logic        start;
   logic        done;
   logic [23:0] word;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cyc = 0;
   laser_altimeter #(.FIRE_GAP(32'd100)) u_dut (
      .CLOCK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .SUPPLY_OK_I(lvl[0]), .MOTOR_RUN_I(lvl[1]),
      .TRIG_DISCHARGE_I(pls[0]), .ENERGY_LOW_I(lvl[2]), .SUN_NEAR_I(lvl[3]),
      .RETURN_I(pls[1]), .SURVEY_CAMERA_REQ_I(pls[2]), .FIRE_O(fire),
      .SHUTTER_CLOSE_O(shut), .TLM_LOAD_I(load), .TLM_SHIFT_I(shift), .TLM_DATA_O(tdat)
   );
   tlm_sampler u_tlm (
      .clk_i(clk), .rst_n_i(rst_n), .start_i(start), .slow_i(lvl[4]), .data_i(tdat),
      .load_o(load), .shift_o(shift), .word_o(word), .done_o(done)
   );
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic chk(input reg_data_t got, input reg_data_t exp, input string m);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t %s: %h vs %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic chk_in(input reg_data_t got, input reg_data_t lo, input reg_data_t hi);
      num_checks++;
      if ($isunknown(got) || got < lo || got > hi)
      begin
         num_errors++;
         $display("BAD %0t range %h", $time, got);
      end
   endtask : chk_in
   task automatic wr_reg(input reg_addr_t a, input reg_data_t d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input reg_addr_t a, output reg_data_t d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask : rd_reg
   task pulse(input int i);
      @(posedge clk);
      pls[i] <= 1'b1;
      @(posedge clk);
      pls[i] <= 1'b0;
   endtask : pulse
   task automatic get_word();
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (100)
      begin
         @(negedge clk);
         if (done === 1'b1)
            break;
      end
      chk({31'h0, done}, 32'h1, "word done");
   endtask : get_word
   task automatic try_fire(input reg_data_t d, input logic exp);
      logic s;
      wr_reg(8'h00, d);
      s = 1'b0;
      repeat (6)
      begin
         @(negedge clk);
         if (fire === 1'b1)
            s = 1'b1;
      end
      chk({31'h0, s}, {31'h0, exp}, "fire");
   endtask : try_fire
   task automatic t_regs();
      reg_data_t d;
      rd_reg(8'h0c, d);
      chk(d, 32'h0, "min reset");
      rd_reg(8'h10, d);
      chk(d, 32'h3ffff, "max reset");
      rd_reg(8'h20, d);
      chk(d, 32'h0, "unmapped");
      wr_reg(8'h0c, 32'h5);
      wr_reg(8'h10, 32'h28);
      rd_reg(8'h10, d);
      chk(d, 32'h28, "max");
      $display("t_regs done");
   endtask : t_regs
   task automatic t_range();
      try_fire(32'h1, 1'b1);
      repeat (20) @(posedge clk);
      pulse(1);
      rd_reg(8'h08, alt);
      chk_in(alt, 32'd13, 32'd18);
      get_word();
      chk({14'h0, word[23:6]}, alt, "word alt");
      chk({26'h0, word[5:0]}, 32'h30, "word events");
      $display("t_range done");
   endtask : t_range
   task automatic t_refuse();
      reg_data_t d;
      try_fire(32'h1, 1'b0);
      repeat (110) @(posedge clk);
      lvl[3] <= 1'b1;
      try_fire(32'h1, 1'b0);
      chk({31'h0, shut}, 32'h1, "sun shut");
      @(posedge clk);
      lvl[3] <= 1'b0;
      wr_reg(8'h00, 32'h4);
      try_fire(32'h5, 1'b0);
      chk({31'h0, shut}, 32'h1, "forced shut");
      wr_reg(8'h00, 32'h0);
      try_fire(32'h1, 1'b1);
      repeat (100) @(posedge clk);
      rd_reg(8'h08, d);
      chk(d, alt, "alt held");
      get_word();
      chk({31'h0, word[1]}, 32'h1, "overflow");
      $display("t_refuse done");
   endtask : t_refuse
   task automatic t_events();
      logic [23:0] w;
      @(posedge clk);
      lvl <= 5'h12;
      repeat (4) @(posedge clk);
      get_word();
      w = word;
      chk({30'h0, w[5:4]}, 32'h1, "levels");
      pulse(0);
      pulse(2);
      @(posedge clk);
      lvl <= 5'h15;
      repeat (4) @(posedge clk);
      get_word();
      chk({26'h0, word[5:0]}, {26'h0, 2'b10, ~w[3], ~w[2], w[1], 1'b1}, "events");
      get_word();
      chk({31'h0, word[0]}, 32'h0, "camera cleared");
      $display("t_events done");
   endtask : t_events
   task automatic t_auto();
      reg_data_t d;
      wr_reg(8'h00, 32'h2);
      rd_reg(8'h00, d);
      chk(d, 32'h2, "ctrl auto");
      pulse(2);
      @(negedge clk);
      chk({31'h0, fire}, 32'h1, "auto fire");
      rd_reg(8'h04, d);
      chk({28'h0, d[8:6], d[1]}, 32'h6, "status");
      $display("t_auto done");
   endtask : t_auto
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         num_errors++;
         $display("BAD %0t timeout", $time);
         conclude();
      end
   end
   initial
   begin
      {rst_n, addr, wdata, wr, rd, pls, start} = '0;
      lvl = 5'h03;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_range();
      t_refuse();
      t_events();
      t_auto();
      conclude();
   end
endmodule : tb
`default_nettype wire
